//--- rtl/uotg_irq_role.sv
// Interrupt status groups, role reporting, host negotiation and PHY power.
// Contract
// - Combined status read returns general flags and endpoint 0 to 3 flags, and clears general flags.
// - Combined view carries endpoint flags for endpoints 0 to 3 only.
// - Control status read returns only control flags and clears them.
// - Endpoint status read returns host and device flags for all endpoints, clears them.
// - Supply error flag is raised only while acting as host.
// - Session start flag is raised only in OTG operation.
// - Session end flag is raised only while acting as device.
// - Detach flag is raised only while acting as host; attach flag while host or on negotiation success as B side device.
// - Overrun frame flag host only; frame start flag in any role.
// - Bus reset flag device only; resume flag in any role.
// - Suspend flag is raised only while acting as device.
// - Cable mode done flag is raised only in OTG operation.
// - Power fault flag is raised only while acting as host.
// - OTG role is host or device on A side or B side.
// - Session request without a cable gives device role on B side.
// - OTG controller reports undetermined role when not resolving its role.
// - Dual mode controller reports host, device or inactive, exactly one.
// - B side device with negotiation enabled starts negotiation at next suspend.
// - Successful negotiation raises attach flag and drives bus reset.
// - Host suspend request gives back the negotiated host role.
// - With the transceiver off, all bus operation stops until powered on.
// - Transceiver is powered on after reset.
`timescale 1ns/1ps
`include "uotg_defines.svh"
module uotg_irq_role #(
  parameter int NumEp = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   otgCapable,
  input  wire logic                   dualHostSel,
  input  wire logic                   dualDevSel,
  input  wire logic                   sessionReq,
  input  wire logic                   cableAttached,
  input  wire logic                   cableIsA,
  input  wire logic                   peerTakesHost,
  input  wire logic                   negotiationEnable,
  input  wire logic                   hnpPeerReady,
  input  wire logic                   hostResetRelease,
  input  wire logic                   hostSuspendReq,
  input  wire logic                   phyOffCmd,
  input  wire logic                   phyOnCmd,
  input  wire logic                   evSupplyErr,
  input  wire logic                   evSessionStart,
  input  wire logic                   evSessionEnd,
  input  wire logic                   evAttach,
  input  wire logic                   evDetach,
  input  wire logic                   evFrameStart,
  input  wire logic                   evBabble,
  input  wire logic                   evBusReset,
  input  wire logic                   evResume,
  input  wire logic                   evSuspend,
  input  wire logic                   evModeDone,
  input  wire logic                   evPowerFault,
  input  wire logic [NumEp-1:0]       epHostEv,
  input  wire logic [NumEp-1:0]       epDevEv,
  input  wire logic                   rdCombined,
  input  wire logic                   rdControl,
  input  wire logic                   rdEndpoint,
  input  wire logic [`UOTG_GEN_W-1:0]  genEnable,
  input  wire logic [`UOTG_CTRL_W-1:0] ctrlEnable,
  input  wire logic [2*NumEp-1:0]     epEnable,
  output logic      [`UOTG_CMB_W-1:0]  combinedData,
  output logic      [`UOTG_CTRL_W-1:0] controlData,
  output logic      [2*NumEp-1:0]     endpointData,
  output uotg_pkg::uotg_role_type     roleState,
  output logic                        hnpAttempt,
  output logic                        busResetDrive,
  output logic                        busSuspendDrive,
  output logic                        phyPowerOn,
  output logic                        irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  uotg_pkg::uotg_role_type role_q;
  uotg_pkg::uotg_role_type role_d;
  logic                    phyOn_q;
  logic                    hnpPending_q;
  logic                    busReset_q;
  logic                    busSuspend_q;
  logic [`UOTG_CMB_W-1:0]   combined_q;
  logic [`UOTG_CTRL_W-1:0]  control_q;
  logic [2*NumEp-1:0]      endpoint_q;
  logic [`UOTG_CTRL_W-1:0]  ctrlSet;
  logic [`UOTG_GEN_W-1:0]   genSet;
  logic [2*NumEp-1:0]      epSet;
  logic [`UOTG_CTRL_W-1:0]  ctrlFlags;
  logic [`UOTG_GEN_W-1:0]   genFlags;
  logic [2*NumEp-1:0]      epFlags;
  logic                    isHost;
  logic                    isDevice;
  logic                    hnpWin;

  assign isHost   = (role_q == uotg_pkg::role_a_host) || (role_q == uotg_pkg::role_b_host) ||
                    (role_q == uotg_pkg::role_dual_host);
  assign isDevice = (role_q == uotg_pkg::role_a_device) ||
                    (role_q == uotg_pkg::role_b_device) ||
                    (role_q == uotg_pkg::role_dual_device);

  // --------------------------------------------------------------------------
  // Transceiver power
  // --------------------------------------------------------------------------
  // Power-off wins when both commands arrive together, the safer outcome.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phyOn_q <= `UOTG_PHY_RST;
    end else if (phyOffCmd) begin
      phyOn_q <= 1'b0;
    end else if (phyOnCmd) begin
      phyOn_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Host negotiation
  // --------------------------------------------------------------------------
  // Negotiation succeeds when the A side answers while an attempt is pending.
  assign hnpWin = phyOn_q && hnpPending_q && hnpPeerReady &&
                  (role_q == uotg_pkg::role_b_device);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hnpPending_q <= 1'b0;
    end else if (!phyOn_q || role_q != uotg_pkg::role_b_device || hnpWin) begin
      hnpPending_q <= 1'b0;
    end else if (!negotiationEnable || evResume) begin
      hnpPending_q <= 1'b0;
    end else if (evSuspend) begin
      hnpPending_q <= 1'b1;
    end
  end

  // The reset stays on the bus until software lets it go; the 20 ms wait is
  // the software's duty and is not timed here.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busReset_q <= 1'b0;
    end else if (!phyOn_q) begin
      busReset_q <= 1'b0;
    end else if (hnpWin) begin
      busReset_q <= 1'b1;
    end else if (hostResetRelease) begin
      busReset_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busSuspend_q <= 1'b0;
    end else if (!phyOn_q || evResume) begin
      busSuspend_q <= 1'b0;
    end else if (hostSuspendReq && isHost) begin
      busSuspend_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Role
  // --------------------------------------------------------------------------
  always_comb begin
    role_d = role_q;
    if (!phyOn_q) begin
      role_d = otgCapable ? uotg_pkg::role_undetermined : uotg_pkg::role_dual_none;
    end else if (!otgCapable) begin
      if (dualHostSel) begin
        role_d = uotg_pkg::role_dual_host;
      end else if (dualDevSel) begin
        role_d = uotg_pkg::role_dual_device;
      end else begin
        role_d = uotg_pkg::role_dual_none;
      end
    end else begin
      case (role_q)
        uotg_pkg::role_undetermined: begin
          if (sessionReq) begin
            if (cableAttached && cableIsA) begin
              role_d = uotg_pkg::role_a_host;
            end else begin
              role_d = uotg_pkg::role_b_device;
            end
          end
        end
        uotg_pkg::role_a_host: begin
          if (evSessionEnd) begin
            role_d = uotg_pkg::role_undetermined;
          end else if (peerTakesHost) begin
            role_d = uotg_pkg::role_a_device;
          end
        end
        uotg_pkg::role_a_device: begin
          if (evSessionEnd) begin
            role_d = uotg_pkg::role_undetermined;
          end else if (evSuspend) begin
            role_d = uotg_pkg::role_a_host;
          end
        end
        uotg_pkg::role_b_device: begin
          if (evSessionEnd) begin
            role_d = uotg_pkg::role_undetermined;
          end else if (hnpWin) begin
            role_d = uotg_pkg::role_b_host;
          end
        end
        uotg_pkg::role_b_host: begin
          if (evSessionEnd) begin
            role_d = uotg_pkg::role_undetermined;
          end else if (hostSuspendReq) begin
            role_d = uotg_pkg::role_b_device;
          end
        end
        default: begin
          role_d = uotg_pkg::role_undetermined;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      role_q <= uotg_pkg::role_undetermined;
    end else begin
      role_q <= role_d;
    end
  end

  // --------------------------------------------------------------------------
  // Event qualification
  // --------------------------------------------------------------------------
  // Events that do not belong to the present role are dropped, not deferred.
  always_comb begin
    ctrlSet                    = `UOTG_CTRL_RST;
    ctrlSet[`UOTG_CF_SUPPLY]   = evSupplyErr && isHost;
    ctrlSet[`UOTG_CF_SESSION]  = evSessionStart && otgCapable;
    ctrlSet[`UOTG_CF_SESSEND]  = evSessionEnd && isDevice;
    ctrlSet[`UOTG_CF_DETACH]   = evDetach && isHost;
    ctrlSet[`UOTG_CF_ATTACH]   = (evAttach && isHost) || hnpWin;
    ctrlSet[`UOTG_CF_FRAME]    = evFrameStart;
    ctrlSet[`UOTG_CF_BABBLE]   = evBabble && isHost;
    ctrlSet[`UOTG_CF_BUSRST]   = evBusReset && isDevice;
    ctrlSet[`UOTG_CF_RESUME]   = evResume;
    ctrlSet[`UOTG_CF_SUSPEND]  = evSuspend && isDevice;
    ctrlSet[`UOTG_CF_MODE]     = evModeDone && otgCapable;
    ctrlSet[`UOTG_CF_POWER]    = evPowerFault && isHost;
    if (!phyOn_q) begin
      ctrlSet = `UOTG_CTRL_RST;
    end
  end

  assign genSet = ctrlSet[`UOTG_GEN_W-1:0];
  assign epSet  = phyOn_q ? {epDevEv, epHostEv} : '0;

  // --------------------------------------------------------------------------
  // Status groups
  // --------------------------------------------------------------------------
  uotg_sticky #(
    .Width    (`UOTG_GEN_W),
    .ResetVal (64'h0000_0000_0000_0000)
  ) u_gen (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setVec  (genSet),
    .clrAll  (rdCombined),
    .flags   (genFlags)
  );

  uotg_sticky #(
    .Width    (`UOTG_CTRL_W),
    .ResetVal (64'h0000_0000_0000_0000)
  ) u_ctrl (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setVec  (ctrlSet),
    .clrAll  (rdControl),
    .flags   (ctrlFlags)
  );

  uotg_sticky #(
    .Width    (2*NumEp),
    .ResetVal (64'h0000_0000_0000_0000)
  ) u_ep (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .setVec  (epSet),
    .clrAll  (rdEndpoint),
    .flags   (epFlags)
  );

  // Read data holds the flags as they stood in the read cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      combined_q <= `UOTG_CMB_RST;
    end else if (rdCombined) begin
      combined_q <= {epFlags[NumEp +: `UOTG_CMB_EP_N],
                     epFlags[0 +: `UOTG_CMB_EP_N], genFlags};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_q <= `UOTG_CTRL_RST;
    end else if (rdControl) begin
      control_q <= ctrlFlags;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      endpoint_q <= '0;
    end else if (rdEndpoint) begin
      endpoint_q <= epFlags;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign combinedData    = combined_q;
  assign controlData     = control_q;
  assign endpointData    = endpoint_q;
  assign roleState       = role_q;
  assign hnpAttempt      = hnpPending_q;
  assign busResetDrive   = busReset_q;
  assign busSuspendDrive = busSuspend_q;
  assign phyPowerOn      = phyOn_q;
  assign irq = |(genFlags & genEnable) || |(ctrlFlags & ctrlEnable) ||
               |(epFlags & epEnable);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence hnpArmSeq;
    role_q == uotg_pkg::role_b_device && negotiationEnable && evSuspend && phyOn_q &&
    !evResume && !evSessionEnd && !hnpWin;
  endsequence

  // The A side may answer any number of cycles after the attempt is armed.
  sequence hnpAnswerSeq;
    hnpPending_q && hnpPeerReady && phyOn_q && !evSessionEnd &&
    role_q == uotg_pkg::role_b_device;
  endsequence

  hnp_start_a: assert property (hnpArmSeq |=> hnpPending_q)
    else $error("negotiation not armed after suspend");

  hnp_success_a: assert property (hnpAnswerSeq |=>
      role_q == uotg_pkg::role_b_host && busReset_q && ctrlFlags[`UOTG_CF_ATTACH])
    else $error("negotiation success did not take host role with reset");

  gen_clear_a: assert property (rdCombined |=> genFlags == $past(genSet))
    else $error("general flags not cleared by combined read");

  ctrl_clear_a: assert property (rdControl |=> controlData == $past(ctrlFlags) &&
      ctrlFlags == $past(ctrlSet))
    else $error("control read data or clear wrong");

  ep_clear_a: assert property (rdEndpoint |=> epFlags == $past(epSet))
    else $error("endpoint flags not cleared by endpoint read");

  cmb_ep_a: assert property (rdCombined |=>
      combinedData[`UOTG_CMB_EPH_LSB +: `UOTG_CMB_EP_N] == $past(epFlags[3:0]))
    else $error("combined view endpoint field wrong");

  power_host_a: assert property ($rose(ctrlFlags[`UOTG_CF_POWER]) |-> $past(isHost))
    else $error("power fault flag raised outside host role");

  babble_host_a: assert property ($rose(ctrlFlags[`UOTG_CF_BABBLE]) |-> $past(isHost))
    else $error("overrun flag raised outside host role");

  suspend_dev_a: assert property ($rose(ctrlFlags[`UOTG_CF_SUSPEND]) |-> $past(isDevice))
    else $error("suspend flag raised outside device role");

  flag_hold_a: assert property (ctrlFlags[`UOTG_CF_RESUME] && !rdControl |=>
      ctrlFlags[`UOTG_CF_RESUME])
    else $error("pending flag lost without a read");

  no_cable_a: assert property (role_q == uotg_pkg::role_undetermined && sessionReq &&
      !cableAttached && otgCapable && phyOn_q |=> role_q == uotg_pkg::role_b_device)
    else $error("session without cable did not give B side device");

  dual_role_a: assert property (phyOn_q && !otgCapable |=>
      role_q inside {uotg_pkg::role_dual_host, uotg_pkg::role_dual_device,
                     uotg_pkg::role_dual_none})
    else $error("dual mode role out of range");

  phy_off_a: assert property (!phyOn_q |=> ctrlFlags == $past(ctrlFlags) || $past(rdControl)
      ##0 !busReset_q)
    else $error("bus activity while transceiver off");

endmodule

//--- rtl/uotg_defines.svh
// Constants for the OTG interrupt-status and role block.
`ifndef UOTG_DEFINES_SVH
`define UOTG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Group widths
// ----------------------------------------------------------------------------
`define UOTG_CTRL_W      12
`define UOTG_GEN_W       8
`define UOTG_CMB_EP_N    4
`define UOTG_CMB_W       16

// ----------------------------------------------------------------------------
// Control flag positions (general group uses bits 0 to 7 of the same order)
// ----------------------------------------------------------------------------
`define UOTG_CF_SUPPLY   0
`define UOTG_CF_SESSION  1
`define UOTG_CF_SESSEND  2
`define UOTG_CF_DETACH   3
`define UOTG_CF_ATTACH   4
`define UOTG_CF_FRAME    5
`define UOTG_CF_BABBLE   6
`define UOTG_CF_BUSRST   7
`define UOTG_CF_RESUME   8
`define UOTG_CF_SUSPEND  9
`define UOTG_CF_MODE     10
`define UOTG_CF_POWER    11

// ----------------------------------------------------------------------------
// Combined view layout
// ----------------------------------------------------------------------------
`define UOTG_CMB_GEN_LSB 0
`define UOTG_CMB_EPH_LSB 8
`define UOTG_CMB_EPD_LSB 12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UOTG_CTRL_RST    12'h000
`define UOTG_GEN_RST     8'h00
`define UOTG_CMB_RST     16'h0000
`define UOTG_PHY_RST     1'b1

`endif

//--- rtl/uotg_pkg.sv
// Types shared by the OTG interrupt-status and role block.
package uotg_pkg;

  // --------------------------------------------------------------------------
  // Reported role
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    role_undetermined,
    role_a_host,
    role_a_device,
    role_b_host,
    role_b_device,
    role_dual_host,
    role_dual_device,
    role_dual_none
  } uotg_role_type;

endpackage

//--- rtl/uotg_sticky.sv
// Sticky event flags cleared as a group, where a new event beats the clear.
`timescale 1ns/1ps
module uotg_sticky #(
  parameter int          Width    = 8,
  parameter logic [63:0] ResetVal = 64'h0000_0000_0000_0000
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [Width-1:0] setVec,
  input  wire logic             clrAll,
  output logic      [Width-1:0] flags
);

  // --------------------------------------------------------------------------
  // One flag per bit
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < Width; i++) begin : g_bit
    logic flag_q;
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        flag_q <= ResetVal[i];
      end else if (setVec[i]) begin
        // An event in the clearing cycle survives into the next read.
        flag_q <= 1'b1;
      end else if (clrAll) begin
        flag_q <= 1'b0;
      end
    end
    assign flags[i] = flag_q;
  end

endmodule

//--- tb/uotg_peer_model.sv
// Far-side cable model: attach state, line events and the A side negotiation answer.
`timescale 1ns/1ps
module uotg_peer_model (
  input  wire logic       clk_sys,
  input  wire logic       hnpAttempt,
  input  wire logic [3:0] answerDelay,
  output logic            cableAttached = 1'b0,
  output logic            cableIsA      = 1'b0,
  output logic            hnpPeerReady  = 1'b0,
  output logic            peerTakesHost = 1'b0,
  output logic [11:0]     lineEv        = 12'h000
);
  logic [3:0] waitCnt = 4'h0;

  // The A side answers only after answerDelay cycles, so prompt and slow peers both exist.
  always @(negedge clk_sys) begin
    hnpPeerReady <= hnpAttempt && (waitCnt >= answerDelay);
    waitCnt <= hnpAttempt ? waitCnt + 4'h1 : 4'h0;
  end

  task automatic send(input logic [11:0] ev);
    lineEv = ev;
    @(negedge clk_sys);
    lineEv = 12'h000;
  endtask

  task automatic plugA();
    cableAttached = 1'b1;
    cableIsA = 1'b1;
  endtask

  task automatic takeHost();
    peerTakesHost = 1'b1;
    @(negedge clk_sys);
    peerTakesHost = 1'b0;
  endtask
endmodule

//--- tb/uotg_testbench.sv
// Self-checking bench for the OTG interrupt-status and role block.
`timescale 1ns/1ps
`include "uotg_defines.svh"
module testbench;
  function automatic logic [11:0] cf(input int p);
    return 12'h001 << p;
  endfunction
  localparam int NumEp = 16;
  localparam int Hold = 2000;
  localparam int Ceiling = 20000;
  localparam logic [11:0] Any = cf(`UOTG_CF_FRAME) | cf(`UOTG_CF_RESUME);
  localparam logic [11:0] Otg = cf(`UOTG_CF_SESSION) | cf(`UOTG_CF_MODE);
  localparam logic [11:0] Dev = cf(`UOTG_CF_SESSEND) | cf(`UOTG_CF_BUSRST) | cf(`UOTG_CF_SUSPEND);
  localparam logic [11:0] Host = cf(`UOTG_CF_SUPPLY) | cf(`UOTG_CF_DETACH) | cf(`UOTG_CF_ATTACH)
                               | cf(`UOTG_CF_BABBLE) | cf(`UOTG_CF_POWER);

  logic clk_sys = 1'b0, rst_n = 1'b0, otgCapable = 1'b1, dualHostSel = 1'b0, dualDevSel = 1'b0;
  logic sessionReq = 1'b0, negotiationEnable = 1'b0, hostResetRelease = 1'b0;
  logic hostSuspendReq = 1'b0, phyOffCmd = 1'b0, phyOnCmd = 1'b0;
  logic rdCombined = 1'b0, rdControl = 1'b0, rdEndpoint = 1'b0;
  logic [NumEp-1:0] epHostEv = 16'h0000, epDevEv = 16'h0000;
  logic [7:0] genEnable = 8'h00;
  logic [11:0] ctrlEnable = 12'h000;
  logic [2*NumEp-1:0] epEnable = 32'h0000_0000;
  logic [3:0] answerDelay = 4'h5;
  logic cableAttached, cableIsA, hnpPeerReady, peerTakesHost;
  logic [11:0] lineEv;
  logic [15:0] combinedData;
  logic [11:0] controlData;
  logic [2*NumEp-1:0] endpointData;
  uotg_pkg::uotg_role_type roleState;
  logic hnpAttempt, busResetDrive, busSuspendDrive, phyPowerOn, irq;
  int errTotal = 0, totalChecks = 0, cycles = 0;

  uotg_peer_model uPeer (.*);
  uotg_irq_role #(.NumEp(NumEp)) uut (
    .*,
    .evSupplyErr(lineEv[`UOTG_CF_SUPPLY]),
    .evSessionStart(lineEv[`UOTG_CF_SESSION]),
    .evSessionEnd(lineEv[`UOTG_CF_SESSEND]),
    .evAttach(lineEv[`UOTG_CF_ATTACH]),
    .evDetach(lineEv[`UOTG_CF_DETACH]),
    .evFrameStart(lineEv[`UOTG_CF_FRAME]),
    .evBabble(lineEv[`UOTG_CF_BABBLE]),
    .evBusReset(lineEv[`UOTG_CF_BUSRST]),
    .evResume(lineEv[`UOTG_CF_RESUME]),
    .evSuspend(lineEv[`UOTG_CF_SUSPEND]),
    .evModeDone(lineEv[`UOTG_CF_MODE]),
    .evPowerFault(lineEv[`UOTG_CF_POWER])
  );

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkRole(input uotg_pkg::uotg_role_type exp);
    chk("roleState", 32'(exp), 32'(roleState));
  endtask
  task automatic readCtrl(input logic [11:0] exp);
    pulse(rdControl);
    chk("controlData", 32'(exp), 32'(controlData));
  endtask
  task automatic reportAndStop();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == Ceiling) begin
      errTotal++;
      reportAndStop();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(1);
    chk("phyPowerOn", 1'b1, phyPowerOn);
    chk("irq", 1'b0, irq);
    chkRole(uotg_pkg::role_undetermined);
    pulse(sessionReq);
    chkRole(uotg_pkg::role_b_device);
    uPeer.send(12'hFFF);
    chkRole(uotg_pkg::role_undetermined);
    tick(3);
    chk("irq", 1'b0, irq);
    ctrlEnable = cf(`UOTG_CF_RESUME);
    tick(1);
    chk("irq", 1'b1, irq);
    chk("hnpAttempt", 1'b0, hnpAttempt);
    readCtrl(Any | Otg | Dev);
    chk("irq", 1'b0, irq);
    genEnable = 8'h20;
    tick(1);
    chk("irq", 1'b1, irq);
    pulse(rdCombined);
    chk("combinedData", 32'((Any | Otg | Dev) & 12'h0FF), 32'(combinedData));
    chk("irq", 1'b0, irq);
    pulse(rdCombined);
    chk("combinedData", 32'h0000_0000, 32'(combinedData));
    epEnable = 32'h0000_0020;
    epHostEv = 16'h0021;
    epDevEv = 16'h0008;
    uPeer.send(cf(`UOTG_CF_FRAME));
    epHostEv = 16'h0000;
    epDevEv = 16'h0000;
    chk("irq", 1'b1, irq);
    pulse(rdCombined);
    chk("combinedData", 32'h0000_8120, 32'(combinedData));
    pulse(rdEndpoint);
    chk("endpointData", 32'h0008_0021, endpointData);
    chk("irq", 1'b0, irq);
    pulse(rdEndpoint);
    chk("endpointData", 32'h0000_0000, endpointData);
    readCtrl(cf(`UOTG_CF_FRAME));
    // The earlier session end left no role, so a new session is needed before negotiating.
    pulse(sessionReq);
    chkRole(uotg_pkg::role_b_device);
    // The peer answers late on purpose, so the attempt must stay pending meanwhile.
    negotiationEnable = 1'b1;
    uPeer.send(cf(`UOTG_CF_SUSPEND));
    chk("hnpAttempt", 1'b1, hnpAttempt);
    for (int i = 0; i < 20 && roleState !== uotg_pkg::role_b_host; i++) tick(1);
    chkRole(uotg_pkg::role_b_host);
    chk("busResetDrive", 1'b1, busResetDrive);
    readCtrl(cf(`UOTG_CF_SUSPEND) | cf(`UOTG_CF_ATTACH));
    negotiationEnable = 1'b0;
    // The release wait is scaled down to keep the run short; the block does not time it.
    tick(Hold);
    chk("busResetDrive", 1'b1, busResetDrive);
    pulse(hostResetRelease);
    chk("busResetDrive", 1'b0, busResetDrive);
    // A session end here would drop the host role before the give-back test.
    uPeer.send(12'hFFF & ~cf(`UOTG_CF_SESSEND));
    readCtrl(Host | Any | Otg);
    pulse(hostSuspendReq);
    chkRole(uotg_pkg::role_b_device);
    chk("busSuspendDrive", 1'b1, busSuspendDrive);
    uPeer.send(cf(`UOTG_CF_RESUME));
    chk("busSuspendDrive", 1'b0, busSuspendDrive);
    readCtrl(cf(`UOTG_CF_RESUME));
    pulse(phyOffCmd);
    tick(1);
    chk("phyPowerOn", 1'b0, phyPowerOn);
    chkRole(uotg_pkg::role_undetermined);
    uPeer.send(12'hFFF);
    pulse(phyOnCmd);
    chk("phyPowerOn", 1'b1, phyPowerOn);
    readCtrl(12'h000);
    uPeer.plugA();
    pulse(sessionReq);
    chkRole(uotg_pkg::role_a_host);
    uPeer.takeHost();
    chkRole(uotg_pkg::role_a_device);
    rst_n = 1'b0;
    otgCapable = 1'b0;
    dualHostSel = 1'b1;
    dualDevSel = 1'b1;
    tick(16);
    rst_n = 1'b1;
    tick(2);
    chkRole(uotg_pkg::role_dual_host);
    dualHostSel = 1'b0;
    tick(2);
    chkRole(uotg_pkg::role_dual_device);
    dualDevSel = 1'b0;
    tick(2);
    chkRole(uotg_pkg::role_dual_none);
    reportAndStop();
  end
endmodule
